/* File: common/pixel_tone_cfg.svh */
// Purpose: constants of the pixel tone and edge control block
// Assumes: 32-bit APB, byte addresses, one register per word
// Notes: fixed-point: ratios Q4.8, gain steps Q1.8, gamma Q2.8, amount Q8.8
`ifndef PIXEL_TONE_CFG_SVH
`define PIXEL_TONE_CFG_SVH

`define REG_CTRL 8'h00
`define REG_GAIN 8'h04
`define REG_SEL 8'h08
`define REG_OFF_RAW 8'h0c
`define REG_OFF_PCT 8'h10
`define REG_RATIO 8'h14
`define REG_GAMMA 8'h18
`define REG_AMOUNT 8'h1c
`define REG_THRESH 8'h20
`define REG_LUT_IDX 8'h24
`define REG_LUT_DATA 8'h28
`define REG_STATUS 8'h2c

`define CTRL_SHARP 0
`define CTRL_SELF_THR 1
`define CTRL_TONE 2
`define CTRL_DARK 3
`define CTRL_LUT 4
`define CTRL_GAIN_MODE 8
`define CTRL_AWB_MODE 10
`define SEL_PATH 0
`define SEL_COLOUR 4

`define FRAC_BITS 5'h08
`define FRAC16 5'h10
`define ONE_Q8 12'h100
`define GAMMA_RST 10'h100
`define AMOUNT_RST 16'h0200
`define AMOUNT_MIN 16'hff00
`define AMOUNT_MAX 16'h0800
`define THRESH_MAX 16'h4000
`define GAIN_DB_MAX 5'h18
`define DB_PER_OCTAVE 5'h06
`define GAIN_STEPS {9'h1c8, 9'h196, 9'h16a, 9'h142, 9'h11f, 9'h100}
`define AG_HEADROOM 5'h03
`define NOISE_SHIFT 3'h4
`define PCT_TO_RAW_K 32'h000028f3
`define PCT_FROM_RAW_K 32'h00000640
`define RATIO_MAX 12'hfff
`define RATIO_MIN 12'h001

`endif

/* File: common/pixel_tone_pkg.sv */
// Purpose: shared types of the pixel tone and edge control block
// Assumes: field codes match the control register layout
// Notes: code 3 of a mode field is folded to off on write
`default_nettype none
package pixel_tone_pkg;
  typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_ONCE = 2'h1, MODE_CONT = 2'h2} self_mode_t;
  typedef enum logic [1:0] {PATH_ALL = 2'h0, PATH_ANALOG = 2'h1, PATH_DIGITAL = 2'h2} offset_path_t;
  typedef enum logic [1:0] {COL_GREEN = 2'h0, COL_RED = 2'h1, COL_BLUE = 2'h2} colour_t;
endpackage
`default_nettype wire

/* File: logic/tone_power.sv */
// Purpose: raise each pixel to a fractional power, one register stage
// Assumes: gamma is Q2.8, pixel is normalised to full scale
// Notes: log2/exp2 by linear mantissa, error up to a few percent
`include "pixel_tone_cfg.svh"
`default_nettype none
module tone_power #(
  parameter int PIX_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic on,
  input wire logic [9:0] gamma,
  input wire logic [PIX_W-1:0] pixIn,
  input wire logic validIn,
  input wire logic lastIn,
  output logic [PIX_W-1:0] pixOut,
  output logic validOut,
  output logic lastOut
);
  typedef struct packed {
    logic v;
    logic l;
    logic [PIX_W-1:0] p;
  } state_t;
  localparam logic [PIX_W-1:0] PMAX = '1;
  localparam logic [31:0] FULL_LOG = 32'(PIX_W) << `FRAC_BITS;
  state_t s_reg, s_next;
  logic [4:0] msb;
  logic [PIX_W-1:0] norm;
  logic [31:0] lg, nl, prod, q, expo;
  logic [PIX_W-1:0] powered;

  // leading one gives the integer log, bits below it the mantissa
  always_comb begin
    msb = '0;
    for (int i = 0; i < PIX_W; i++) begin
      if (pixIn[i]) msb = 5'(i);
    end
  end
  assign norm = pixIn << (5'(PIX_W - 1) - msb);
  assign lg = {19'h0, msb, norm[PIX_W-2 -: 8]};
  assign nl = FULL_LOG - lg;
  assign prod = (nl * 32'(gamma)) >> `FRAC_BITS;
  assign q = FULL_LOG - prod;
  assign expo = ((32'h100 + 32'(q[7:0])) << q[12:8]) >> `FRAC_BITS;

  // zero stays zero; a result at or past full scale saturates
  always_comb begin
    if (pixIn == '0 || prod > FULL_LOG) powered = '0;
    else if (expo > 32'(PMAX)) powered = PMAX;
    else powered = expo[PIX_W-1:0];
  end

  always_comb begin
    s_next.v = validIn;
    s_next.l = validIn & lastIn;
    s_next.p = on ? powered : pixIn;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign pixOut = s_reg.p;
  assign validOut = s_reg.v;
  assign lastOut = s_reg.l;

  chk_bypass_linear: assert property (@(posedge clk) disable iff (!arst_n)
    (validIn && !on) |=> (pixOut == $past(pixIn) && validOut))
    else $error("tone power altered pixel while off");
  chk_unity_power: assert property (@(posedge clk) disable iff (!arst_n)
    (validIn && on && gamma == `GAMMA_RST && pixIn[PIX_W-1]) |=> pixOut >= $past(pixIn) - 8'h40)
    else $error("unity gamma moved a bright pixel too far");
endmodule
`default_nettype wire

/* File: logic/pixel_tone_and_sharpen_control.sv */
// Purpose: offset, gain, colour ratio, tone power, lookup and edge stages
// Assumes: pixels synchronous to clk, one per valid, last marks frame end
// Notes: six cycles from input valid to output valid, no back-pressure
//
// Our own choices: the APB slave port and the register offsets.
`include "pixel_tone_cfg.svh"
`default_nettype none
module pixel_tone_and_sharpen_control #(
  parameter int PIX_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [PIX_W-1:0] pixIn,
  input wire logic pixInValid,
  input wire logic pixInLast,
  input wire logic [1:0] pixInColour,
  output logic [PIX_W-1:0] pixOut,
  output logic pixOutValid,
  output logic pixOutLast
);
  generate
    if (PIX_W < 10 || PIX_W > 16) begin : g_bad_width
      $error("PIX_W must lie between 10 and 16");
    end
  endgenerate

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic slverr;
    logic sharpOn;
    logic selfThr;
    logic toneOn;
    logic darkOn;
    logic lutOn;
    pixel_tone_pkg::self_mode_t gainMode;
    pixel_tone_pkg::self_mode_t awbMode;
    pixel_tone_pkg::offset_path_t path;
    logic colourSel;
    logic [15:0] offRaw;
    logic [4:0] gainDb;
    logic [11:0] ratioRed;
    logic [11:0] ratioBlue;
    logic [9:0] gamma;
    logic [15:0] amount;
    logic [15:0] thresh;
    logic [PIX_W-1:0] lutIdx;
    logic [PIX_W-1:0] darkMin;
    logic [PIX_W-1:0] darkLevel;
    logic [PIX_W-1:0] frameMax;
    logic [31:0] sumR;
    logic [31:0] sumG;
    logic [31:0] sumB;
    logic [PIX_W-1:0] noise;
    logic v1, l1, v2, l2, v3, l3, v5, l5, vo, lo;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [1:0] c3;
    logic [PIX_W-1:0] p1;
    logic [PIX_W-1:0] p2;
    logic [PIX_W-1:0] p3;
    logic [PIX_W-1:0] p5;
    logic [PIX_W-1:0] po;
    logic [PIX_W-1:0] h1;
    logic [PIX_W-1:0] h2;
    logic [1:0] age;
  } state_t;

  localparam logic [PIX_W-1:0] PMAX = '1;
  localparam logic [53:0] GSTEPS = `GAIN_STEPS;
  localparam state_t RST = '{
    gainMode: pixel_tone_pkg::MODE_OFF, awbMode: pixel_tone_pkg::MODE_OFF,
    path: pixel_tone_pkg::PATH_ALL, ratioRed: `ONE_Q8, ratioBlue: `ONE_Q8,
    gamma: `GAMMA_RST, amount: `AMOUNT_RST, darkMin: PMAX, default: '0};

  state_t s_reg, s_next;
  logic [PIX_W-1:0] lut [1 << PIX_W];

  function automatic logic [PIX_W-1:0] clampPix(input logic signed [31:0] x);
    if (x < 0) return '0;
    else if (x > $signed(32'(PMAX))) return PMAX;
    else return x[PIX_W-1:0];
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wd, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) old[8*i +: 8] = wd[8*i +: 8];
    end
    return old;
  endfunction

  function automatic pixel_tone_pkg::self_mode_t toMode(input logic [1:0] f);
    return (f == 2'h3) ? pixel_tone_pkg::MODE_OFF : pixel_tone_pkg::self_mode_t'(f);
  endfunction

  logic access, wrDone, mapped;
  logic [31:0] rdMux, wr;
  logic signed [31:0] selRaw, pctRaw;
  logic signed [17:0] offEff;
  logic [PIX_W-1:0] pix1, pix2, pix3, pix5, tpPix, n1, n2, sharpOut, minNow, maxNow;
  logic [4:0] gq, gr;
  logic [8:0] gm;
  logic [11:0] ratio;
  logic [31:0] gainProd, balProd, thrPix, autoWide;
  logic tpValid, tpLast, apply;
  logic [PIX_W:0] avg;
  logic signed [PIX_W+1:0] d;
  logic [PIX_W+1:0] ad;
  logic signed [PIX_W+2:0] nd;
  logic [15:0] autoThr, thrFrac;
  logic signed [31:0] corr;

  // APB: answer one cycle into the access phase, act on the sampled edge
  assign access = psel & penable;
  assign wrDone = access & s_reg.ready & pwrite;
  assign wr = mergeBytes(rdMux, pwdata, pstrb);

  // the digital path shows the clamp correction, analog is never set here
  always_comb begin
    case (s_reg.path)
      pixel_tone_pkg::PATH_ALL: selRaw = 32'($signed(s_reg.offRaw));
      pixel_tone_pkg::PATH_DIGITAL: selRaw = s_reg.darkOn ? -32'(s_reg.darkLevel) : '0;
      default: selRaw = '0;
    endcase
  end
  assign pctRaw = (32'($signed(wr[15:0])) * $signed(`PCT_TO_RAW_K)) >>> `FRAC16;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      `REG_CTRL: rdMux = {20'h0, s_reg.awbMode, s_reg.gainMode, 3'h0, s_reg.lutOn,
                          s_reg.darkOn, s_reg.toneOn, s_reg.selfThr, s_reg.sharpOn};
      `REG_GAIN: rdMux = {27'h0, s_reg.gainDb};
      `REG_SEL: rdMux = {27'h0, s_reg.colourSel, 2'h0, s_reg.path};
      `REG_OFF_RAW: rdMux = selRaw;
      `REG_OFF_PCT: rdMux = (selRaw * $signed(`PCT_FROM_RAW_K)) >>> `FRAC_BITS;
      `REG_RATIO: rdMux = {20'h0, s_reg.colourSel ? s_reg.ratioBlue : s_reg.ratioRed};
      `REG_GAMMA: rdMux = {22'h0, s_reg.gamma};
      `REG_AMOUNT: rdMux = 32'($signed(s_reg.amount));
      `REG_THRESH: rdMux = {16'h0, thrFrac};
      `REG_LUT_IDX: rdMux = 32'(s_reg.lutIdx);
      `REG_LUT_DATA: rdMux = 32'(lut[s_reg.lutIdx]);
      `REG_STATUS: rdMux = {16'(s_reg.noise), 16'(s_reg.darkLevel)};
      default: begin
        rdMux = '0;
        mapped = 1'b0;
      end
    endcase
  end

  // offset stage, dark level taken off when clamping is on
  assign offEff = $signed(s_reg.darkOn ? 18'($signed(s_reg.offRaw)) - 18'(s_reg.darkLevel)
                                       : 18'($signed(s_reg.offRaw)));
  assign pix1 = clampPix(32'($signed({1'b0, pixIn})) + 32'(offEff));
  assign minNow = (pixIn < s_reg.darkMin) ? pixIn : s_reg.darkMin;

  // gain stage: whole octaves by shift, the rest by a six-entry step table
  assign gq = s_reg.gainDb / `DB_PER_OCTAVE;
  assign gr = s_reg.gainDb % `DB_PER_OCTAVE;
  assign gm = GSTEPS[9*gr +: 9];
  assign gainProd = ((32'(s_reg.p1) * 32'(gm)) << gq) >> `FRAC_BITS;
  assign pix2 = clampPix($signed(gainProd));
  assign maxNow = (s_reg.p2 > s_reg.frameMax) ? s_reg.p2 : s_reg.frameMax;

  // colour ratio stage, green passes at unity
  assign ratio = (s_reg.c2 == pixel_tone_pkg::COL_RED) ? s_reg.ratioRed :
                 (s_reg.c2 == pixel_tone_pkg::COL_BLUE) ? s_reg.ratioBlue : `ONE_Q8;
  assign balProd = (32'(s_reg.p2) * 32'(ratio)) >> `FRAC_BITS;
  assign pix3 = clampPix($signed(balProd));

  tone_power #(.PIX_W(PIX_W)) u_tone (
    .clk(clk),
    .arst_n(arst_n),
    .on(s_reg.toneOn),
    .gamma(s_reg.gamma),
    .pixIn(s_reg.p3),
    .validIn(s_reg.v3),
    .lastIn(s_reg.l3),
    .pixOut(tpPix),
    .validOut(tpValid),
    .lastOut(tpLast)
  );

  // lookup follows tone power, so the table sees corrected values
  assign pix5 = s_reg.lutOn ? lut[tpPix] : tpPix;

  always_ff @(posedge clk) begin
    if (wrDone && paddr == `REG_LUT_DATA) lut[s_reg.lutIdx] <= pwdata[PIX_W-1:0];
  end

  // edge stage on two earlier pixels; causal, so no flush at frame end
  assign n1 = (s_reg.age == 2'h0) ? s_reg.p5 : s_reg.h1;
  assign n2 = (s_reg.age == 2'h2) ? s_reg.h2 : n1;
  assign avg = ({1'b0, n1} + {1'b0, n2}) >> 1;
  assign d = $signed({2'b0, s_reg.p5}) - $signed({1'b0, avg});
  assign ad = d[PIX_W+1] ? (PIX_W+2)'(-d) : d;
  assign autoWide = 32'(s_reg.noise) << (17 - PIX_W);
  assign autoThr = (autoWide > 32'(`THRESH_MAX)) ? `THRESH_MAX : autoWide[15:0];
  assign thrFrac = s_reg.selfThr ? autoThr : s_reg.thresh;
  assign thrPix = (32'(thrFrac) * 32'(PMAX)) >> `FRAC16;
  assign apply = s_reg.sharpOn && (32'(ad) > thrPix);
  assign corr = ($signed(32'($signed(s_reg.amount))) * 32'(d)) >>> `FRAC_BITS;
  assign sharpOut = apply ? clampPix($signed(32'(s_reg.p5)) + corr) : s_reg.p5;
  assign nd = $signed({1'b0, ad}) - $signed({3'b0, s_reg.noise});

  always_comb begin
    s_next = s_reg;
    s_next.ready = access & ~s_reg.ready;
    s_next.rdata = (access & ~s_reg.ready & ~pwrite) ? rdMux : '0;
    s_next.slverr = access & ~s_reg.ready & ~mapped;
    // pixel pipeline registers
    s_next.v1 = pixInValid;
    s_next.l1 = pixInValid & pixInLast;
    s_next.c1 = pixInColour;
    s_next.p1 = pix1;
    s_next.v2 = s_reg.v1;
    s_next.l2 = s_reg.l1;
    s_next.c2 = s_reg.c1;
    s_next.p2 = pix2;
    s_next.v3 = s_reg.v2;
    s_next.l3 = s_reg.l2;
    s_next.c3 = s_reg.c2;
    s_next.p3 = pix3;
    s_next.v5 = tpValid;
    s_next.l5 = tpLast;
    s_next.p5 = pix5;
    s_next.vo = s_reg.v5;
    s_next.lo = s_reg.l5;
    s_next.po = sharpOut;
    if (s_reg.v5) begin
      s_next.h1 = s_reg.p5;
      s_next.h2 = s_reg.h1;
      s_next.age = s_reg.l5 ? 2'h0 : (s_reg.age == 2'h2 ? 2'h2 : s_reg.age + 2'h1);
      s_next.noise = PIX_W'($signed({3'b0, s_reg.noise}) + (nd >>> `NOISE_SHIFT));
    end
    // darkest input of a frame becomes the next frame's dark level
    if (pixInValid) begin
      s_next.darkMin = minNow;
      if (pixInLast) begin
        s_next.darkLevel = minNow;
        s_next.darkMin = PMAX;
      end
    end
    // auto gain: step up while the top eighth is unused, down on clipping
    if (s_reg.v2) begin
      s_next.frameMax = maxNow;
      if (s_reg.l2) begin
        s_next.frameMax = '0;
        if (s_reg.gainMode != pixel_tone_pkg::MODE_OFF) begin
          if (maxNow < PMAX - (PMAX >> `AG_HEADROOM) && s_reg.gainDb < `GAIN_DB_MAX)
            s_next.gainDb = s_reg.gainDb + 5'h1;
          else if (maxNow == PMAX && s_reg.gainDb != 5'h0)
            s_next.gainDb = s_reg.gainDb - 5'h1;
          if (s_reg.gainMode == pixel_tone_pkg::MODE_ONCE)
            s_next.gainMode = pixel_tone_pkg::MODE_OFF;
        end
      end
    end
    // auto balance: bayer carries two greens per red and per blue
    if (s_reg.v3) begin
      case (s_reg.c3)
        pixel_tone_pkg::COL_RED: s_next.sumR = s_reg.sumR + 32'(s_reg.p3);
        pixel_tone_pkg::COL_BLUE: s_next.sumB = s_reg.sumB + 32'(s_reg.p3);
        default: s_next.sumG = s_reg.sumG + 32'(s_reg.p3);
      endcase
      if (s_reg.l3) begin
        s_next.sumR = '0;
        s_next.sumG = '0;
        s_next.sumB = '0;
        if (s_reg.awbMode != pixel_tone_pkg::MODE_OFF) begin
          if ({s_reg.sumR, 1'b0} < {1'b0, s_reg.sumG} && s_reg.ratioRed != `RATIO_MAX)
            s_next.ratioRed = s_reg.ratioRed + 12'h1;
          else if ({s_reg.sumR, 1'b0} > {1'b0, s_reg.sumG} && s_reg.ratioRed != `RATIO_MIN)
            s_next.ratioRed = s_reg.ratioRed - 12'h1;
          if ({s_reg.sumB, 1'b0} < {1'b0, s_reg.sumG} && s_reg.ratioBlue != `RATIO_MAX)
            s_next.ratioBlue = s_reg.ratioBlue + 12'h1;
          else if ({s_reg.sumB, 1'b0} > {1'b0, s_reg.sumG} && s_reg.ratioBlue != `RATIO_MIN)
            s_next.ratioBlue = s_reg.ratioBlue - 12'h1;
          if (s_reg.awbMode == pixel_tone_pkg::MODE_ONCE)
            s_next.awbMode = pixel_tone_pkg::MODE_OFF;
        end
      end
    end
    // host writes come last so they win over a same-cycle auto update
    if (wrDone) begin
      case (paddr)
        `REG_CTRL: begin
          s_next.sharpOn = wr[`CTRL_SHARP];
          s_next.selfThr = wr[`CTRL_SELF_THR];
          s_next.toneOn = wr[`CTRL_TONE];
          s_next.darkOn = wr[`CTRL_DARK];
          s_next.lutOn = wr[`CTRL_LUT];
          s_next.gainMode = toMode(wr[`CTRL_GAIN_MODE +: 2]);
          s_next.awbMode = toMode(wr[`CTRL_AWB_MODE +: 2]);
        end
        `REG_GAIN: if (s_reg.gainMode == pixel_tone_pkg::MODE_OFF)
          s_next.gainDb = (wr[4:0] > `GAIN_DB_MAX) ? `GAIN_DB_MAX : wr[4:0];
        `REG_SEL: begin
          s_next.path = (wr[1:0] == 2'h3) ? pixel_tone_pkg::PATH_ALL
                                          : pixel_tone_pkg::offset_path_t'(wr[1:0]);
          s_next.colourSel = wr[`SEL_COLOUR];
        end
        `REG_OFF_RAW: if (s_reg.path == pixel_tone_pkg::PATH_ALL)
          s_next.offRaw = wr[15:0];
        `REG_OFF_PCT: if (s_reg.path == pixel_tone_pkg::PATH_ALL)
          s_next.offRaw = pctRaw[15:0];
        `REG_RATIO: if (s_reg.awbMode == pixel_tone_pkg::MODE_OFF) begin
          if (s_reg.colourSel) s_next.ratioBlue = wr[11:0];
          else s_next.ratioRed = wr[11:0];
        end
        `REG_GAMMA: s_next.gamma = wr[9:0];
        `REG_AMOUNT: begin
          if ($signed(wr[15:0]) < $signed(`AMOUNT_MIN)) s_next.amount = `AMOUNT_MIN;
          else if ($signed(wr[15:0]) > $signed(`AMOUNT_MAX)) s_next.amount = `AMOUNT_MAX;
          else s_next.amount = wr[15:0];
        end
        `REG_THRESH: if (!s_reg.selfThr)
          s_next.thresh = (wr[15:0] > `THRESH_MAX) ? `THRESH_MAX : wr[15:0];
        `REG_LUT_IDX: s_next.lutIdx = wr[PIX_W-1:0];
        `REG_LUT_DATA: s_next.lutIdx = s_reg.lutIdx + 1'b1;
        default: ;
      endcase
    end
  end

  // reset leaves edge stage off and amount at two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) s_reg <= RST;
    else s_reg <= s_next;
  end

  assign pready = s_reg.ready;
  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.slverr;
  assign pixOut = s_reg.po;
  assign pixOutValid = s_reg.vo;
  assign pixOutLast = s_reg.lo;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_edge_off_bypass: assert property ((s_reg.v5 && !s_reg.sharpOn) |=>
    (pixOut == $past(s_reg.p5) && pixOutValid)) else $error("pixel changed with edge off");
  chk_below_limit_pass: assert property ((s_reg.v5 && ad <= (PIX_W+2)'(thrPix)) |=>
    pixOut == $past(s_reg.p5)) else $error("pixel below gradient limit was changed");
  chk_amount_bounds: assert property ($signed(s_reg.amount) >= $signed(`AMOUNT_MIN) &&
    $signed(s_reg.amount) <= $signed(`AMOUNT_MAX)) else $error("amount out of range");
  chk_amount_default: assert property (!$past(arst_n) |->
    s_reg.amount == `AMOUNT_RST) else $error("amount not two after reset");
  chk_thresh_quarter: assert property (s_reg.thresh <= `THRESH_MAX &&
    thrFrac <= `THRESH_MAX) else $error("threshold above one quarter");
  chk_self_thr_ignore: assert property ((wrDone && paddr == `REG_THRESH && s_reg.selfThr)
    |=> $stable(s_reg.thresh)) else $error("threshold write taken in self mode");
  chk_gain_once_off: assert property ((s_reg.v2 && s_reg.l2 &&
    s_reg.gainMode == pixel_tone_pkg::MODE_ONCE && !(wrDone && paddr == `REG_CTRL))
    |=> s_reg.gainMode == pixel_tone_pkg::MODE_OFF) else $error("once mode did not return");
  chk_offset_readonly: assert property ((wrDone && paddr == `REG_OFF_RAW &&
    s_reg.path != pixel_tone_pkg::PATH_ALL) |=> $stable(s_reg.offRaw))
    else $error("read-only offset path was written");
  chk_gain_manual_hold: assert property ((s_reg.gainMode == pixel_tone_pkg::MODE_OFF &&
    !(wrDone && paddr == `REG_GAIN)) |=> $stable(s_reg.gainDb)) else $error("gain drifted");
  chk_pipe_latency: assert property (pixInValid |-> ##6 pixOutValid)
    else $error("pixel did not leave six cycles later");
endmodule
`default_nettype wire

/* File: tb/sensor_feed.sv */
// Purpose: sensor readout stand-in feeding one frame per go pulse
// Assumes: one pixel per valid, no back-pressure from the pipeline
// Notes: idle gaps are random, idle data toggles so stale data never looks valid
`default_nettype none
module sensor_feed #(
  parameter int PIX_W = 12
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [PIX_W-1:0] lo,
  input wire logic [PIX_W-1:0] hi,
  input wire logic rnd,
  output logic [PIX_W-1:0] pixIn,
  output logic pixInValid,
  output logic pixInLast,
  output logic [1:0] pixInColour,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // frame: first half lo, second half hi, or random values
  initial begin
    pixIn = '0;
    pixInValid = 1'b0;
    pixInLast = 1'b0;
    pixInColour = 2'h0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < int'(len); i++) begin
          repeat ($urandom_range(2)) begin
            pixInValid <= 1'b0;
            pixInLast <= 1'b0;
            pixIn <= ~pixIn;
            pixInColour <= ~pixInColour;
            @(posedge clk);
          end
          pixInValid <= 1'b1;
          pixInLast <= (i == int'(len) - 1);
          pixInColour <= 2'($urandom_range(2));
          pixIn <= rnd ? PIX_W'($urandom) : (i < int'(len) / 2 ? lo : hi);
          @(posedge clk);
        end
        pixInValid <= 1'b0;
        pixInLast <= 1'b0;
        busy <= 1'b0;
      end else begin
        pixIn <= ~pixIn;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/pixel_tone_and_sharpen_control_tb_top.sv */
// Purpose: self-checking bench of the pixel tone and edge block
// Assumes: one wait state on the register bus, six cycles pixel latency
// Notes: edge results are checked by direction, exact maths left to the design
`include "pixel_tone_cfg.svh"
`default_nettype none
module pixel_tone_and_sharpen_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 12;
  typedef struct {logic [31:0] m; logic [31:0] d; logic e;} reg_note_t;
  typedef struct {int t; logic [PW-1:0] v; logic l; int k;} pix_note_t;
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic go = 1'b0, rnd = 1'b0;
  logic [7:0] paddr = 8'h00, len = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, pixInValid, pixInLast, pixOutValid, pixOutLast, busy;
  logic [31:0] prdata;
  logic [PW-1:0] pixIn, pixOut, lo = '0, hi = '0;
  logic [1:0] pixInColour;
  reg_note_t regQ[$];
  pix_note_t pixQ[$];
  int fails = 0, samplesChecked = 0, cyc = 0, idx = 0, stepKind = 0;
  always #2.5 clk = ~clk;
  pixel_tone_and_sharpen_control #(.PIX_W(PW)) pixel_tone_and_sharpen_control_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pixIn(pixIn), .pixInValid(pixInValid), .pixInLast(pixInLast),
    .pixInColour(pixInColour), .pixOut(pixOut), .pixOutValid(pixOutValid),
    .pixOutLast(pixOutLast));
  sensor_feed #(.PIX_W(PW)) sensor_feed_inst (
    .clk(clk), .go(go), .len(len), .lo(lo), .hi(hi), .rnd(rnd), .pixIn(pixIn),
    .pixInValid(pixInValid), .pixInLast(pixInLast), .pixInColour(pixInColour), .busy(busy));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // notes taken at the input edge, compared when the answer shows
  always @(posedge clk) begin
    reg_note_t rn;
    pix_note_t pn;
    int k;
    cyc <= cyc + 1;
    if (psel && penable && pready && regQ.size() > 0) begin
      rn = regQ.pop_front();
      check("prdata", prdata & rn.m, rn.d);
      check("pslverr", {31'h0, pslverr}, {31'h0, rn.e});
    end
    if (pixInValid) begin
      k = (idx > int'(len) / 2 && stepKind > 0) ? 3 : 0;
      pixQ.push_back('{cyc, pixIn, pixInLast, (idx == int'(len) / 2) ? stepKind : k});
      idx <= pixInLast ? 0 : idx + 1;
    end
    if (pixOutValid && pixQ.size() == 0) check("spare pixel", 32'h1, 32'h0);
    if (pixOutValid && pixQ.size() > 0) begin
      pn = pixQ.pop_front();
      check("latency", cyc - pn.t, 6);
      check("last", {31'h0, pixOutLast}, {31'h0, pn.l});
      if (pn.k == 0) check("pixel", {20'h0, pixOut}, {20'h0, pn.v});
      if (pn.k == 1) check("boost", {31'h0, pixOut > pn.v}, 32'h1);
      if (pn.k == 2) check("smooth", {31'h0, pixOut < pn.v}, 32'h1);
    end
  end
  // one transfer; the request holds until pready is seen high or 50 cycles pass
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, logic [31:0] m,
                     logic [31:0] ex, logic er);
    int n = 0;
    @(posedge clk);
    regQ.push_back('{m, ex, er});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] ex, logic [31:0] m = '1, logic er = 1'b0);
    apb(1'b0, a, 32'h0, m, ex, er);
  endtask
  // one frame from the sensor stand-in, then drain the pipeline
  task automatic frame(logic [7:0] n, logic [PW-1:0] l, logic [PW-1:0] h, logic r, int k);
    int w = 0;
    @(posedge clk);
    len <= n;
    lo <= l;
    hi <= h;
    rnd <= r;
    stepKind <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (busy) fails++;
    repeat (10) @(posedge clk);
  endtask
  task automatic endOfTest();
    check("pending pixels", pixQ.size(), 0);
    check("pending transfers", regQ.size(), 0);
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run
  initial begin
    #200000;
    fails++;
    endOfTest();
  end
  initial begin
    void'($urandom(32'h1d57eb40));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(`REG_CTRL, 32'h0);
    rd(`REG_AMOUNT, 32'h200, 32'hffff);
    rd(`REG_THRESH, 32'h0, 32'hffff);
    rd(8'h30, 32'h0, '1, 1'b1);
    wr(`REG_THRESH, 32'hffff);
    rd(`REG_THRESH, 32'h4000, 32'hffff);
    wr(`REG_THRESH, 32'h1234);
    rd(`REG_THRESH, 32'h1234, 32'hffff);
    wr(`REG_AMOUNT, 32'h7fff);
    rd(`REG_AMOUNT, 32'h0800, 32'hffff);
    wr(`REG_AMOUNT, 32'hffff8000);
    rd(`REG_AMOUNT, 32'hff00, 32'hffff);
    wr(`REG_SEL, 32'h1);
    wr(`REG_OFF_RAW, 32'h55);
    rd(`REG_OFF_RAW, 32'h0);
    wr(`REG_SEL, 32'h0);
    wr(`REG_OFF_RAW, 32'h10);
    rd(`REG_OFF_RAW, 32'h10);
    wr(`REG_OFF_RAW, 32'h0);
    frame(8'd40, 12'h000, 12'h000, 1'b1, 0);
    wr(`REG_THRESH, 32'h4000);
    wr(`REG_AMOUNT, 32'h0800);
    wr(`REG_CTRL, 32'h1);
    frame(8'd20, 12'h400, 12'h410, 1'b0, 0);
    wr(`REG_THRESH, 32'h0);
    wr(`REG_AMOUNT, 32'h0200);
    frame(8'd20, 12'h400, 12'h800, 1'b0, 1);
    wr(`REG_AMOUNT, 32'hff00);
    frame(8'd20, 12'h400, 12'h800, 1'b0, 2);
    wr(`REG_CTRL, 32'h2);
    wr(`REG_THRESH, 32'h1000);
    wr(`REG_CTRL, 32'h0);
    rd(`REG_THRESH, 32'h0, 32'hffff);
    wr(`REG_CTRL, 32'h100);
    wr(`REG_GAIN, 32'h5);
    rd(`REG_GAIN, 32'h0, 32'h1f);
    frame(8'd20, 12'h100, 12'h100, 1'b0, 0);
    rd(`REG_CTRL, 32'h0, 32'h300);
    rd(`REG_GAIN, 32'h1, 32'h1f);
    wr(`REG_GAIN, 32'h0);
    wr(`REG_CTRL, 32'h4);
    frame(8'd20, 12'h800, 12'hc00, 1'b0, 0);
    endOfTest();
  end
endmodule
`default_nettype wire
